// *** design/dps_pkg.sv ***
package dps_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W_DEF = 19;
    localparam int DATA_W_DEF = 18;
    localparam int BYTE_W     = 9;
    localparam int BURST_LEN  = 4;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // read latency in half cycles of the input clock pair
    // ------------------------------------------------------------
    localparam logic [2:0] LAT_HALF_PLL_ON  = 3'h5;
    localparam logic [2:0] LAT_HALF_PLL_OFF = 3'h2;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS      = 4'h0;
    localparam logic [3:0] REG_CLEAR       = 4'h4;
    localparam int         STAT_OVR_BIT    = 0;
    localparam int         STAT_EMPTY_BIT  = 1;
    localparam int         STAT_FETCH_BIT  = 2;
    localparam int         STAT_LEVEL_LSB  = 4;
    localparam int         CLR_OVR_BIT     = 0;
    localparam logic       OVR_RST         = 1'b0;

    typedef struct packed {
        logic k;
        logic k_n;
        logic rd_sel_n;
        logic wr_sel_n;
        logic pll_off;
    } dps_ctl_t;

    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_WAIT = 2'b01,
        FS_READ = 2'b10
    } dps_fetch_t;

endpackage

// *** design/dps_sram.sv ***
`timescale 1ns/100ps
`default_nettype none

module dps_fifo
    import dps_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [WIDTH-1:0]       in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [WIDTH-1:0]            out_data,
    output logic [$clog2(DEPTH):0]      level
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH)
        $error("fifo depth must be a power of two");

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW:0]      wp_r;
    logic [PW:0]      rp_r;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;
    wire              full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);

    assign in_ready  = ~full;
    assign out_valid = (wp_r != rp_r);
    assign out_data  = mem[rp_r[PW-1:0]];
    assign level     = wp_r - rp_r;

    always_ff @(posedge sys_clk)
        if (push)
            mem[wp_r[PW-1:0]] <= in_data;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + (PW+1)'(push);
            rp_r <= rp_r + (PW+1)'(pop);
        end
    end
endmodule

module dps_sram
    import dps_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
)
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire logic                     in_clk,
    input  wire logic                     in_clk_n,
    input  wire logic                     rd_sel_n,
    input  wire logic                     wr_sel_n,
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic [DATA_W-1:0]        wr_data,
    input  wire logic [DATA_W/BYTE_W-1:0] byte_write_select_n,
    input  wire logic                     pll_off_select,
    output logic [DATA_W-1:0]             read_data,
    output logic                          read_valid_flag,
    output logic                          echo_clock,
    output logic                          echo_clock_n,
    input  wire logic [3:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata
);
    localparam int BW = DATA_W / BYTE_W;
    localparam int FW = ADDR_W + 2 + BW + DATA_W;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (DATA_W != 18 && DATA_W != 36)
        $error("data width must be 18 or 36");
    if (ADDR_W < 1 || ADDR_W > 24)
        $error("address width out of range");

    // ------------------------------------------------------------
    // pin sampling: three flops, a change counts when 2nd and 3rd agree
    // ------------------------------------------------------------
    dps_ctl_t          c1_r, c2_r, c3_r;
    logic [ADDR_W-1:0] a1_r, a2_r, a3_r;
    logic [DATA_W-1:0] d1_r, d2_r, d3_r;
    logic [BW-1:0]     b1_r, b2_r, b3_r;
    logic              k_f_r;
    logic              kn_f_r;
    logic              pll_f_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            c1_r <= '0;
            c2_r <= '0;
            c3_r <= '0;
        end
        else
        begin
            c1_r <= '{in_clk, in_clk_n, rd_sel_n, wr_sel_n, pll_off_select};
            c2_r <= c1_r;
            c3_r <= c2_r;
        end
    end

    // data stages need no reset: only read when a slot takes them
    always_ff @(posedge sys_clk)
    begin
        a1_r <= addr;
        a2_r <= a1_r;
        a3_r <= a2_r;
        d1_r <= wr_data;
        d2_r <= d1_r;
        d3_r <= d2_r;
        b1_r <= byte_write_select_n;
        b2_r <= b1_r;
        b3_r <= b2_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            k_f_r   <= 1'b0;
            kn_f_r  <= 1'b0;
            pll_f_r <= 1'b0;
        end
        else
        begin
            k_f_r   <= (c2_r.k == c3_r.k) ? c3_r.k : k_f_r;
            kn_f_r  <= (c2_r.k_n == c3_r.k_n) ? c3_r.k_n : kn_f_r;
            pll_f_r <= (c2_r.pll_off == c3_r.pll_off) ? c3_r.pll_off : pll_f_r;
        end
    end

    // falling edges are never looked at
    wire k_rise  = c2_r.k & c3_r.k & ~k_f_r;
    wire kn_rise = c2_r.k_n & c3_r.k_n & ~kn_f_r;
    wire half    = k_rise | kn_rise;

    // ------------------------------------------------------------
    // address slots: read on even true edges, write on odd ones
    // ------------------------------------------------------------
    logic phase_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            phase_r <= 1'b0;
        end
        else if (k_rise)
            phase_r <= ~phase_r;
    end

    wire rd_take = k_rise & ~phase_r & ~c3_r.rd_sel_n;
    wire wr_take = k_rise & phase_r & ~c3_r.wr_sel_n;

    // ------------------------------------------------------------
    // write port capture: four words on the halves after the address
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] wa_r;
    logic [1:0]        wi_r;
    logic [2:0]        wl_r;
    logic              push;
    logic              push_rdy;
    logic              ovr_r;

    assign push = half & (wl_r != 3'h0);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wl_r <= 3'h0;
        end
        else if (wr_take)
        begin
            wa_r <= a3_r;
            wi_r <= 2'h0;
            wl_r <= 3'(BURST_LEN);
        end
        else if (push)
        begin
            wi_r <= wi_r + 2'h1;
            wl_r <= wl_r - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // write buffer and self-timed array write
    // ------------------------------------------------------------
    dps_fetch_t        fs_r;
    logic              drain_vld;
    logic              drain_rdy;
    logic [FW-1:0]     drain_word;
    logic [LW-1:0]     fifo_level;

    // a burst read owns the array, so writes stall and the buffer fills
    assign drain_rdy = (fs_r != FS_READ);

    dps_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (push_rdy),
        .in_data   ({wa_r, wi_r, b3_r, d3_r}),
        .out_valid (drain_vld),
        .out_ready (drain_rdy),
        .out_data  (drain_word),
        .level     (fifo_level)
    );

    wire                    drain  = drain_vld & drain_rdy;
    wire [ADDR_W+1:0]       dr_wa  = drain_word[FW-1 -: ADDR_W+2];
    wire [BW-1:0]           dr_bws = drain_word[DATA_W +: BW];
    wire [DATA_W-1:0]       dr_d   = drain_word[DATA_W-1:0];

    logic [ADDR_W-1:0]      fa_r;
    logic [1:0]             fi_r;
    logic [DATA_W-1:0]      rd_word;
    wire  [ADDR_W+1:0]      rd_idx = {fa_r, fi_r};

    for (genvar g = 0; g < BW; g++)
    begin : g_lane
        logic [BYTE_W-1:0] lane_mem [0:(1 << (ADDR_W+2))-1];

        always_ff @(posedge sys_clk)
        begin
            if (drain && !dr_bws[g])
                lane_mem[dr_wa] <= dr_d[g*BYTE_W +: BYTE_W];
            rd_word[g*BYTE_W +: BYTE_W] <= lane_mem[rd_idx];
        end
    end

    // ------------------------------------------------------------
    // read fetch: wait for the write buffer to empty, then read four
    // ------------------------------------------------------------
    logic       slot_ptr_r;
    logic       fslot_r;
    logic       cap_r;
    logic [1:0] cap_idx_r;
    logic       cap_slot_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            fs_r       <= FS_IDLE;
            slot_ptr_r <= 1'b0;
        end
        else
        begin
            if (rd_take)
            begin
                fa_r       <= a3_r;
                fslot_r    <= slot_ptr_r;
                slot_ptr_r <= ~slot_ptr_r;
            end
            case (fs_r)
                FS_IDLE:
                    fs_r <= rd_take ? FS_WAIT : FS_IDLE;
                FS_WAIT:
                begin
                    if (!drain_vld && !push)
                    begin
                        fs_r <= FS_READ;
                        fi_r <= 2'h0;
                    end
                end
                FS_READ:
                begin
                    fi_r <= fi_r + 2'h1;
                    if (fi_r == 2'h3)
                        fs_r <= FS_IDLE;
                end
                default:
                    fs_r <= FS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            cap_r      <= 1'b0;
            cap_idx_r  <= 2'h0;
            cap_slot_r <= 1'b0;
        end
        else
        begin
            cap_r      <= (fs_r == FS_READ);
            cap_idx_r  <= fi_r;
            cap_slot_r <= fslot_r;
        end
    end

    // ------------------------------------------------------------
    // two burst slots, each counting halves down to its launch
    // ------------------------------------------------------------
    wire [2:0] lat_load = pll_f_r ? LAT_HALF_PLL_ON - 3'h1
                                  : LAT_HALF_PLL_OFF - 3'h1;

    logic [DATA_W-1:0] buf_r [0:1][0:BURST_LEN-1];
    logic [1:0]        start;

    for (genvar s = 0; s < 2; s++)
    begin : g_slot
        logic       act_r;
        logic [2:0] cnt_r;

        assign start[s] = half & act_r & (cnt_r == 3'h0);

        always_ff @(posedge sys_clk)
        begin
            if (!rst_b)
            begin
                act_r <= 1'b0;
                cnt_r <= 3'h0;
            end
            else if (rd_take && slot_ptr_r == 1'(s))
            begin
                act_r <= 1'b1;
                cnt_r <= lat_load;
            end
            else if (half && act_r)
            begin
                act_r <= (cnt_r != 3'h0);
                cnt_r <= cnt_r - 3'(cnt_r != 3'h0);
            end
        end

        always_ff @(posedge sys_clk)
        begin
            if (cap_r && cap_slot_r == 1'(s))
                buf_r[s][cap_idx_r] <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // read port output: one word per half, launched on the edge event
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rdq_r;
    logic              rvld_r;
    logic              st_slot_r;
    logic [1:0]        st_idx_r;
    logic [1:0]        st_left_r;
    wire               st_go   = |start;
    wire               go_slot = start[1];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rdq_r     <= '0;
            rvld_r    <= 1'b0;
            st_left_r <= 2'h0;
        end
        else if (half)
        begin
            if (st_go)
            begin
                rdq_r     <= buf_r[go_slot][0];
                rvld_r    <= 1'b1;
                st_slot_r <= go_slot;
                st_idx_r  <= 2'h1;
                st_left_r <= 2'(BURST_LEN - 1);
            end
            else if (st_left_r != 2'h0)
            begin
                rdq_r     <= buf_r[st_slot_r][st_idx_r];
                rvld_r    <= 1'b1;
                st_idx_r  <= st_idx_r + 2'h1;
                st_left_r <= st_left_r - 2'h1;
            end
            else
                rvld_r <= 1'b0;
        end
    end

    assign read_data       = rdq_r;
    assign read_valid_flag = rvld_r;
    // echoes follow the filtered input clocks, changing on the same
    // sys_clk edge as the data they frame
    assign echo_clock      = k_f_r;
    assign echo_clock_n    = kn_f_r;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    wire ovr_set = push & ~push_rdy;
    wire ovr_clr = reg_wr & (reg_addr == REG_CLEAR) & reg_wdata[CLR_OVR_BIT];

    logic [31:0] status;
    logic [31:0] rdata_r;

    always_comb
    begin
        status                            = 32'h0;
        status[STAT_OVR_BIT]              = ovr_r;
        status[STAT_EMPTY_BIT]            = ~drain_vld;
        status[STAT_FETCH_BIT]            = (fs_r != FS_IDLE);
        status[STAT_LEVEL_LSB +: LW]      = fifo_level;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ovr_r   <= OVR_RST;
            rdata_r <= 32'h0;
        end
        else
        begin
            // a lost word in the same cycle as a clear stays flagged
            ovr_r   <= ovr_set | (ovr_r & ~ovr_clr);
            rdata_r <= (reg_rd && reg_addr == REG_STATUS) ? status : 32'h0;
        end
    end

    assign reg_rdata = rdata_r;
endmodule

`default_nettype wire

// *** dv/dps_sram_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module dps_sram_checker
    import dps_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
)
(
    input wire logic                     sys_clk,
    input wire logic                     rst_b,
    input wire logic                     in_clk,
    input wire logic                     in_clk_n,
    input wire logic                     rd_sel_n,
    input wire logic                     wr_sel_n,
    input wire logic [ADDR_W-1:0]        addr,
    input wire logic [DATA_W-1:0]        wr_data,
    input wire logic [DATA_W/BYTE_W-1:0] byte_write_select_n,
    input wire logic                     pll_off_select,
    input wire logic [DATA_W-1:0]        read_data,
    input wire logic                     read_valid_flag,
    input wire logic                     echo_clock,
    input wire logic                     echo_clock_n,
    input wire logic [3:0]               reg_addr,
    input wire logic [31:0]              reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [31:0]              reg_rdata
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // word counter: wraps to zero only after whole bursts
    // ------------------------------------------------------------
    logic       echo_q;
    logic       echo_n_q;
    logic [1:0] word_cnt_r;
    wire        half_ev = (echo_clock & ~echo_q) | (echo_clock_n & ~echo_n_q);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            echo_q     <= 1'b0;
            echo_n_q   <= 1'b0;
            word_cnt_r <= 2'h0;
        end
        else
        begin
            echo_q     <= echo_clock;
            echo_n_q   <= echo_clock_n;
            word_cnt_r <= !read_valid_flag ? 2'h0 : word_cnt_r + {1'b0, half_ev};
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_echo_true: assert property ($rose(in_clk) |-> ##[2:5] $rose(echo_clock))
        else $error("true echo late");
    a_echo_comp: assert property ($rose(in_clk_n) |-> ##[2:5] $rose(echo_clock_n))
        else $error("complementary echo late");
    a_echo_idle: assert property (!in_clk [*6] |-> !echo_clock)
        else $error("echo high with clock low");
    a_word_on_rise: assert property ($changed(read_data) |->
        $rose(echo_clock) || $rose(echo_clock_n))
        else $error("read word moved off a rise");
    a_valid_on_rise: assert property ($changed(read_valid_flag) |->
        $rose(echo_clock) || $rose(echo_clock_n))
        else $error("read valid moved off a rise");
    a_data_only_valid: assert property ($changed(read_data) |-> read_valid_flag)
        else $error("read data changed while not valid");
    a_burst_four: assert property ($fell(read_valid_flag) |-> word_cnt_r == 2'h0)
        else $error("read valid ended inside a burst");
    a_reg_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("register read data without a read");
    a_reg_unmapped: assert property ($past(reg_rd) && $past(reg_addr) != REG_STATUS &&
        $past(reg_addr) != REG_CLEAR |-> reg_rdata == 32'h0)
        else $error("unmapped register read not zero");
    a_status_spare: assert property ($past(reg_rd) && $past(reg_addr) == REG_STATUS |->
        reg_rdata[31:9] == 23'h0 && !reg_rdata[3])
        else $error("spare status bits not zero");

    c_burst_start: cover property ($rose(read_valid_flag));
    c_burst_end: cover property ($fell(read_valid_flag));
    c_status_read: cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule

bind dps_sram dps_sram_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .in_clk(in_clk), .in_clk_n(in_clk_n),
    .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .wr_data(wr_data),
    .byte_write_select_n(byte_write_select_n), .pll_off_select(pll_off_select),
    .read_data(read_data), .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

`default_nettype wire

// *** dv/dps_ctl_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module dps_ctl_model
    import dps_pkg::*;
#(
    parameter int ADDR_W = 6,
    parameter int DATA_W = DATA_W_DEF
)
(
    input  wire logic                     sys_clk,
    input  wire logic                     run,
    output logic                          in_clk,
    output logic                          in_clk_n,
    output logic                          rd_sel_n,
    output logic                          wr_sel_n,
    output logic [ADDR_W-1:0]             addr,
    output logic [DATA_W-1:0]             wr_data,
    output logic [DATA_W/BYTE_W-1:0]      byte_write_select_n
);
    localparam int NB = DATA_W / BYTE_W;

    logic [2:0]        cnt_r = 3'h0;
    int                ev_r = 0;
    logic [ADDR_W-1:0] rd_q[$];
    logic [ADDR_W-1:0] wa_q[$];
    logic [DATA_W-1:0] wd_q[$];
    logic [NB-1:0]     wb_q[$];
    logic [DATA_W-1:0] pd_q[$];
    logic [NB-1:0]     pb_q[$];
    int                iss_q[$];

    // ------------------------------------------------------------
    // input clock pair, eight system cycles a period
    // ------------------------------------------------------------
    assign in_clk   = run & ~cnt_r[2];
    assign in_clk_n = run & cnt_r[2];

    initial
    begin
        rd_sel_n            = 1'b1;
        wr_sel_n            = 1'b1;
        addr                = '0;
        wr_data             = '0;
        byte_write_select_n = '0;
    end

    // ------------------------------------------------------------
    // each half event is prepared one system cycle ahead of it
    // ------------------------------------------------------------
    task automatic prep(input int n);
        logic rd_ok;
        logic wr_ok;
        rd_ok = (n % 4 == 0) && (rd_q.size() > 0);
        wr_ok = (n % 4 == 2) && (wa_q.size() > 0);
        rd_sel_n <= !rd_ok;
        wr_sel_n <= !wr_ok;
        // idle lines toggle so a stale value is never mistaken for a request
        if (pd_q.size() > 0)
        begin
            wr_data             <= pd_q.pop_front();
            byte_write_select_n <= pb_q.pop_front();
        end
        else
        begin
            wr_data             <= ~wr_data;
            byte_write_select_n <= ~byte_write_select_n;
        end
        if (rd_ok)
        begin
            addr <= rd_q.pop_front();
            iss_q.push_back(n);
        end
        else if (wr_ok)
        begin
            addr <= wa_q.pop_front();
            repeat (4)
            begin
                pd_q.push_back(wd_q.pop_front());
                pb_q.push_back(wb_q.pop_front());
            end
        end
        else
            addr <= ~addr;
    endtask

    always @(posedge sys_clk)
    begin
        if (run)
        begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r[1:0] == 2'h3)
                ev_r <= ev_r + 1;
            if (cnt_r[1:0] == 2'h2)
                prep(ev_r + 1);
        end
    end
endmodule

`default_nettype wire

// *** dv/dps_sram_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module dps_sram_tb
    import dps_pkg::*;
;
    localparam int AW = 6;
    localparam int DW = 18;

    logic sys_clk, rst_b, run, pll_off_select, reg_wr, reg_rd, in_clk, in_clk_n;
    logic rd_sel_n, wr_sel_n, read_valid_flag, echo_clock, echo_clock_n, echo_q, echo_n_q;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    wr_data, read_data;
    logic [1:0]       byte_write_select_n;
    logic [3:0]       reg_addr;
    logic [31:0]      reg_wdata, reg_rdata, d;
    logic [DW-1:0]    mem[0:255];
    logic [DW-1:0]    got_d[$];
    logic [DW-1:0]    exp_d[$];
    int               got_e[$];
    int               err_count, checks_done, hev;

    dps_sram #(.ADDR_W(AW), .DATA_W(DW)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .in_clk(in_clk), .in_clk_n(in_clk_n),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .wr_data(wr_data),
        .byte_write_select_n(byte_write_select_n), .pll_off_select(pll_off_select),
        .read_data(read_data), .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
        .echo_clock_n(echo_clock_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    dps_ctl_model #(.ADDR_W(AW), .DATA_W(DW)) ctl (
        .sys_clk(sys_clk), .run(run), .in_clk(in_clk), .in_clk_n(in_clk_n),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .wr_data(wr_data),
        .byte_write_select_n(byte_write_select_n));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // read words are collected at each echo rise, with its index
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        echo_q   <= echo_clock;
        echo_n_q <= echo_clock_n;
        if ((echo_clock && !echo_q) || (echo_clock_n && !echo_n_q))
        begin
            if (read_valid_flag === 1'b1)
            begin
                got_d.push_back(read_data);
                got_e.push_back(hev);
            end
            hev++;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // byte selects: two active-low bits a word, word 0 lowest
    task wr(input int a, input int t, input logic [7:0] bmask);
        logic [DW-1:0] w;
        logic [1:0]    b;
        for (int i = 0; i < 4; i++)
        begin
            w = {t[7:0], a[5:0], i[1:0], 2'b01};
            b = bmask[2*i +: 2];
            ctl.wd_q.push_back(w);
            ctl.wb_q.push_back(b);
            if (!b[0]) mem[a*4+i][8:0] = w[8:0];
            if (!b[1]) mem[a*4+i][17:9] = w[17:9];
        end
        ctl.wa_q.push_back(AW'(a));
    endtask

    task rd(input int a);
        for (int i = 0; i < 4; i++)
            exp_d.push_back(mem[a*4+i]);
        ctl.rd_q.push_back(AW'(a));
    endtask

    // wait until the model has sent the last write, then until its words are in
    task wait_taken;
        int k;
        k = 0;
        while (ctl.wa_q.size() > 0 && k < 200)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 200)
        begin
            check("write address taken", 0, 1);
            end_sim;
        end
        repeat (28) @(posedge sys_clk);
    endtask

    task settle(input int lat);
        int k;
        k = 0;
        while (got_d.size() < exp_d.size() && k < 400)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 400)
        begin
            check("read word count", got_d.size(), exp_d.size());
            end_sim;
        end
        for (int j = 0; j < exp_d.size(); j++)
        begin
            check("read word", got_d[j], exp_d[j]);
            check("read word slot", got_e[j], ctl.iss_q[j/4] + lat + j % 4);
        end
        got_d.delete();
        got_e.delete();
        exp_d.delete();
        ctl.iss_q.delete();
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        run = 1'b0;
        pll_off_select = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        err_count = 0;
        checks_done = 0;
        hev = 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;

        reg_read(REG_STATUS);
        check("status after reset", d, 32'h2);
        reg_read(4'h8);
        check("unmapped read", d, 32'h0);
        reg_write(4'hc, 32'hffffffff);
        reg_write(REG_CLEAR, 32'h1);
        reg_read(REG_STATUS);
        check("status after clear", d, 32'h2);
        $display("test registers done");

        @(posedge sys_clk);
        run <= 1'b1;
        wr(3, 1, 8'h00);
        wait_taken;
        rd(3);
        settle(5);
        $display("test write and read back done");

        wr(5, 2, 8'h00);
        rd(3);
        wr(3, 3, 8'he4);
        wait_taken;
        rd(3);
        rd(5);
        settle(5);
        $display("test concurrent and masked done");

        repeat (32) @(posedge sys_clk);
        pll_off_select <= 1'b0;
        repeat (32) @(posedge sys_clk);
        wr(7, 4, 8'h00);
        wait_taken;
        rd(7);
        rd(3);
        settle(2);
        $display("test short latency done");

        repeat (96) @(posedge sys_clk);
        check("words while deselected", got_d.size(), 0);
        reg_read(REG_STATUS);
        check("status after traffic", d, 32'h2);
        $display("test deselect done");
        end_sim;
    end
endmodule

`default_nettype wire
